// >>> accr_regs.vh
`ifndef ACCR_REGS_VH
`define ACCR_REGS_VH

// ----------------------------------------
// Register indices (byte address = 4 * index)
// ----------------------------------------
`define ACCR_IDX_CHAN      5'h06
`define ACCR_IDX_CMD       5'h08
`define ACCR_IDX_EVT       5'h09
`define ACCR_IDX_IEN       5'h0A
`define ACCR_IDX_FLG       5'h0B
`define ACCR_IDX_DBG       5'h0C
`define ACCR_IDX_TEMP      5'h0D
`define ACCR_IDX_RESL      5'h10
`define ACCR_IDX_RESH      5'h11
`define ACCR_IDX_WLOL      5'h12
`define ACCR_IDX_WLOH      5'h13
`define ACCR_IDX_MODE      5'h18
`define ACCR_IDX_WHIL      5'h19
`define ACCR_IDX_WHIH      5'h1A

// ----------------------------------------
// Field positions
// ----------------------------------------
`define ACCR_BIT_LAUNCH    0
`define ACCR_BIT_EVTEN     0
`define ACCR_BIT_RDY       0
`define ACCR_BIT_WIN       1
`define ACCR_BIT_RUN_WHILE_HALTED    0
`define ACCR_BIT_CONT      0
`define ACCR_POS_ACC       1
`define ACCR_POS_WCS       4

// ----------------------------------------
// Reset values
// ----------------------------------------
`define ACCR_RST_BYTE      8'h00
`define ACCR_RST_WORD      16'h0000

// ----------------------------------------
// Channel codes
// ----------------------------------------
`define ACCR_CH_PIN_LAST   5'h0B
`define ACCR_CH_DAC        5'h1C
`define ACCR_CH_GND        5'h1F

// ----------------------------------------
// Window modes and limits
// ----------------------------------------
`define ACCR_WIN_NONE      3'h0
`define ACCR_WIN_BELOW     3'h1
`define ACCR_WIN_ABOVE     3'h2
`define ACCR_WIN_INSIDE    3'h3
`define ACCR_WIN_OUTSIDE   3'h4
`define ACCR_SAMPLE_MAX    10'h3FF
`define ACCR_ACC_MAX_CODE  3'h6

`endif

// >>> accr_window.v
`timescale 1ns/1ns
`include "accr_regs.vh"

module accr_window (
	input  wire [15:0] value,
	input  wire [15:0] lower,
	input  wire [15:0] upper,
	input  wire [2:0]  mode,
	output reg         match
);

	// ----------------------------------------
	// Window condition
	// ----------------------------------------
	always @* begin
		case (mode)
			`ACCR_WIN_BELOW:   match = value < lower;
			`ACCR_WIN_ABOVE:   match = value > upper;
			`ACCR_WIN_INSIDE:  match = (value > lower) && (value < upper);
			`ACCR_WIN_OUTSIDE: match = (value < lower) || (value > upper);
			default:           match = 1'b0;
		endcase
	end

endmodule // accr_window

// >>> accr_sequencer.v
`timescale 1ns/1ns
`include "accr_regs.vh"

module accr_sequencer (
	input  wire        pclk,
	input  wire        presetn,
	input  wire        start_req,
	input  wire        continuous,
	input  wire [2:0]  accumulation_count,
	input  wire [4:0]  channel_sel,
	input  wire        halted,
	input  wire        sample_valid,
	input  wire [11:0] sample_raw,
	output reg         sample_start,
	output reg  [4:0]  sample_channel,
	output wire        busy,
	output reg         done,
	output reg  [15:0] result
);

	localparam [1:0] ST_IDLE = 2'd0;
	localparam [1:0] ST_REQ  = 2'd1;
	localparam [1:0] ST_WAIT = 2'd2;

	reg  [1:0]  state_q;
	reg  [15:0] acc_q;
	reg  [6:0]  cnt_q;
	reg  [2:0]  code_q;
	wire [9:0]  clipped;
	wire [15:0] sum;
	wire [6:0]  target;
	wire [4:0]  route;

	// ----------------------------------------
	// Input routing, reserved codes to ground
	// ----------------------------------------
	assign route = (channel_sel <= `ACCR_CH_PIN_LAST || channel_sel >= `ACCR_CH_DAC) ?
		channel_sel : `ACCR_CH_GND;

	// ----------------------------------------
	// Clipping and accumulation
	// ----------------------------------------
	assign clipped = sample_raw[11] ? 10'h000 :
		(sample_raw[10] ? `ACCR_SAMPLE_MAX : sample_raw[9:0]);
	assign sum     = acc_q + {6'h00, clipped};
	assign target  = 7'h01 << code_q;
	assign busy    = state_q != ST_IDLE;

	// ----------------------------------------
	// Conversion sequence
	// ----------------------------------------
	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			state_q        <= ST_IDLE;
			acc_q          <= `ACCR_RST_WORD;
			cnt_q          <= 7'h00;
			code_q         <= 3'h0;
			sample_start   <= 1'b0;
			sample_channel <= 5'h00;
			done           <= 1'b0;
			result         <= `ACCR_RST_WORD;
		end else begin
			sample_start <= 1'b0;
			done         <= 1'b0;
			case (state_q)
				ST_IDLE: begin
					if (start_req) begin
						state_q        <= ST_REQ;
						sample_channel <= route;
						acc_q          <= `ACCR_RST_WORD;
						cnt_q          <= 7'h00;
						code_q         <= (accumulation_count > `ACCR_ACC_MAX_CODE) ?
							3'h0 : accumulation_count;
					end
				end
				ST_REQ: begin
					if (!halted) begin
						sample_start <= 1'b1;
						state_q      <= ST_WAIT;
					end
				end
				ST_WAIT: begin
					if (sample_valid) begin
						if (cnt_q + 7'h01 == target) begin
							result <= sum;
							done   <= 1'b1;
							acc_q  <= `ACCR_RST_WORD;
							cnt_q  <= 7'h00;
							if (continuous) begin
								state_q        <= ST_REQ;
								sample_channel <= route;
								code_q         <= (accumulation_count > `ACCR_ACC_MAX_CODE) ?
									3'h0 : accumulation_count;
							end else begin
								state_q <= ST_IDLE;
							end
						end else begin
							acc_q   <= sum;
							cnt_q   <= cnt_q + 7'h01;
							state_q <= ST_REQ;
						end
					end
				end
				default: state_q <= ST_IDLE;
			endcase
		end
	end

endmodule // accr_sequencer

// >>> accr_top.v
// Functional notes
// - Five-bit code routes pins, DAC, reference, sensor, ground
// - Channel change waits for running conversion end
// - Start bit launches one, or first free-run
// - Start bit reads busy, self-clears at end
// - Enabled event starts conversion like software
// - Request only when flag and enable set
// - Result-ready flag sets on every finished measurement
// - Window flag sets when condition met at end
// - Flags clear by one-write or result read
// - Debug halt stops conversions and ignores events
// - Shared eight-bit temporary byte, readable and writable
// - Low byte at base, high byte base+1
// - Single samples clip to 0x000..0x3FF
// - Accumulated result never exceeds 0xFFC0
// - Ten-bit sample into sixteen-bit read-only result
// - Window compares only the final accumulated value
// - Window mode selects below, above, inside, outside
// - Free-run restarts immediately, flag per result
// - Accumulate 1 to 64 samples, code 7 reserved
`timescale 1ns/1ns
`include "accr_regs.vh"

module accr_top #(
	parameter AW = 8
) (
	input  wire          pclk,
	input  wire          presetn,
	input  wire          psel,
	input  wire          penable,
	input  wire          pwrite,
	input  wire [AW-1:0] paddr,
	input  wire [31:0]   pwdata,
	output reg  [31:0]   prdata,
	output wire          pready,
	output wire          pslverr,
	input  wire          event_in,
	input  wire          debug_halt,
	input  wire          sample_valid,
	input  wire [11:0]   sample_raw,
	output wire          sample_start,
	output wire [4:0]    sample_channel,
	output wire          irq_request
);

	// ----------------------------------------
	// Declarations
	// ----------------------------------------
	reg  [4:0]  chan_q;
	reg         evt_en_q;
	reg  [1:0]  ien_q;
	reg  [1:0]  flags_q;
	reg  [1:0]  flags_d;
	reg         dbg_run_q;
	reg  [7:0]  temp_q;
	reg  [15:0] win_lo_q;
	reg  [15:0] win_hi_q;
	reg         cont_q;
	reg  [2:0]  acc_cnt_q;
	reg  [2:0]  wcs_q;
	reg         pready_q;
	reg         perr_q;
	reg  [7:0]  rd_d;
	reg         hit_d;
	wire [4:0]  idx;
	wire        addr_ok;
	wire        access;
	wire        wr_done;
	wire        rd_done;
	wire [7:0]  wb;
	wire        halted;
	wire        sw_start;
	wire        ev_start;
	wire        busy;
	wire        done;
	wire [15:0] result;
	wire        match;
	wire        res_read;
	wire [1:0]  flag_set;
	wire [1:0]  flag_clr;

	// ----------------------------------------
	// Address decode
	// ----------------------------------------
	assign idx     = paddr[6:2];
	assign addr_ok = (paddr[1:0] == 2'b00) && (paddr[AW-1:7] == {(AW-7){1'b0}}) && hit_d;
	assign access  = psel && penable;
	assign wr_done = access && pready_q && pwrite && addr_ok;
	assign rd_done = access && pready_q && !pwrite && addr_ok;
	assign wb      = pwdata[7:0];
	assign pready  = pready_q;
	assign pslverr = perr_q;

	// ----------------------------------------
	// Read multiplexer
	// ----------------------------------------
	always @* begin
		rd_d  = 8'h00;
		hit_d = 1'b1;
		case (idx)
			`ACCR_IDX_CHAN: rd_d = {3'b000, chan_q};
			`ACCR_IDX_CMD:  rd_d = {7'h00, busy};
			`ACCR_IDX_EVT:  rd_d = {7'h00, evt_en_q};
			`ACCR_IDX_IEN:  rd_d = {6'h00, ien_q};
			`ACCR_IDX_FLG:  rd_d = {6'h00, flags_q};
			`ACCR_IDX_DBG:  rd_d = {7'h00, dbg_run_q};
			`ACCR_IDX_TEMP: rd_d = temp_q;
			`ACCR_IDX_RESL: rd_d = result[7:0];
			`ACCR_IDX_RESH: rd_d = temp_q;
			`ACCR_IDX_WLOL: rd_d = win_lo_q[7:0];
			`ACCR_IDX_WLOH: rd_d = temp_q;
			`ACCR_IDX_MODE: rd_d = {1'b0, wcs_q, acc_cnt_q, cont_q};
			`ACCR_IDX_WHIL: rd_d = win_hi_q[7:0];
			`ACCR_IDX_WHIH: rd_d = temp_q;
			default:        hit_d = 1'b0;
		endcase
	end

	// ----------------------------------------
	// APB handshake, one wait state
	// ----------------------------------------
	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pready_q <= 1'b0;
			perr_q   <= 1'b0;
			prdata   <= 32'h0000_0000;
		end else begin
			if (access && !pready_q) begin
				pready_q <= 1'b1;
				perr_q   <= !addr_ok;
				prdata   <= (!pwrite && addr_ok) ? {24'h00_0000, rd_d} : 32'h0000_0000;
			end else begin
				pready_q <= 1'b0;
				perr_q   <= 1'b0;
			end
		end
	end

	// ----------------------------------------
	// Channel selection
	// ----------------------------------------
	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			chan_q <= 5'h00;
		end else if (wr_done && idx == `ACCR_IDX_CHAN) begin
			chan_q <= wb[4:0];
		end
	end

	// ----------------------------------------
	// Event, interrupt enable and debug control
	// ----------------------------------------
	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			evt_en_q  <= 1'b0;
			ien_q     <= 2'b00;
			dbg_run_q <= 1'b0;
		end else if (wr_done) begin
			if (idx == `ACCR_IDX_EVT) begin
				evt_en_q <= wb[`ACCR_BIT_EVTEN];
			end
			if (idx == `ACCR_IDX_IEN) begin
				ien_q <= wb[1:0];
			end
			if (idx == `ACCR_IDX_DBG) begin
				dbg_run_q <= wb[`ACCR_BIT_RUN_WHILE_HALTED];
			end
		end
	end

	// ----------------------------------------
	// Mode control
	// ----------------------------------------
	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			cont_q    <= 1'b0;
			acc_cnt_q <= 3'h0;
			wcs_q     <= `ACCR_WIN_NONE;
		end else if (wr_done && idx == `ACCR_IDX_MODE) begin
			cont_q    <= wb[`ACCR_BIT_CONT];
			acc_cnt_q <= wb[`ACCR_POS_ACC+2:`ACCR_POS_ACC];
			wcs_q     <= wb[`ACCR_POS_WCS+2:`ACCR_POS_WCS];
		end
	end

	// ----------------------------------------
	// Temporary byte and sixteen-bit pairs
	// ----------------------------------------
	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			temp_q <= `ACCR_RST_BYTE;
		end else if (wr_done) begin
			if (idx == `ACCR_IDX_TEMP || idx == `ACCR_IDX_WLOL || idx == `ACCR_IDX_WHIL) begin
				temp_q <= wb;
			end
		end else if (rd_done) begin
			case (idx)
				`ACCR_IDX_RESL: temp_q <= result[15:8];
				`ACCR_IDX_WLOL: temp_q <= win_lo_q[15:8];
				`ACCR_IDX_WHIL: temp_q <= win_hi_q[15:8];
				default:        temp_q <= temp_q;
			endcase
		end
	end

	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			win_lo_q <= `ACCR_RST_WORD;
			win_hi_q <= `ACCR_RST_WORD;
		end else if (wr_done) begin
			if (idx == `ACCR_IDX_WLOH) begin
				win_lo_q <= {wb, temp_q};
			end
			if (idx == `ACCR_IDX_WHIH) begin
				win_hi_q <= {wb, temp_q};
			end
		end
	end

	// ----------------------------------------
	// Start sources and debug halt
	// ----------------------------------------
	assign halted   = debug_halt && !dbg_run_q;
	assign sw_start = wr_done && idx == `ACCR_IDX_CMD && wb[`ACCR_BIT_LAUNCH];
	assign ev_start = evt_en_q && event_in && !halted;

	accr_sequencer u_seq (
		.pclk               (pclk),
		.presetn            (presetn),
		.start_req          (sw_start || ev_start),
		.continuous         (cont_q),
		.accumulation_count (acc_cnt_q),
		.channel_sel        (chan_q),
		.halted             (halted),
		.sample_valid       (sample_valid),
		.sample_raw         (sample_raw),
		.sample_start       (sample_start),
		.sample_channel     (sample_channel),
		.busy               (busy),
		.done               (done),
		.result             (result)
	);

	// ----------------------------------------
	// Window compare on final value
	// ----------------------------------------
	accr_window u_win (
		.value (result),
		.lower (win_lo_q),
		.upper (win_hi_q),
		.mode  (wcs_q),
		.match (match)
	);

	// ----------------------------------------
	// Interrupt flags, set wins over clear
	// ----------------------------------------
	assign res_read = rd_done && (idx == `ACCR_IDX_RESL || idx == `ACCR_IDX_RESH);
	assign flag_set = {done && match, done};
	assign flag_clr = ({2{wr_done && idx == `ACCR_IDX_FLG}} & wb[1:0]) | {2{res_read}};

	always @* begin
		flags_d = (flags_q & ~flag_clr) | flag_set;
	end

	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			flags_q <= 2'b00;
		end else begin
			flags_q <= flags_d;
		end
	end

	assign irq_request = |(flags_q & ien_q);

endmodule // accr_top

// >>> accr_top_assertions.sv
`timescale 1ns/1ns
// ----------------------------------------
// Port checker
// ----------------------------------------
module accr_chk #(
	parameter AW = 8
) (
	input wire          pclk,
	input wire          presetn,
	input wire          psel,
	input wire          penable,
	input wire          pwrite,
	input wire [AW-1:0] paddr,
	input wire [31:0]   pwdata,
	input wire [31:0]   prdata,
	input wire          pready,
	input wire          pslverr,
	input wire          event_in,
	input wire          debug_halt,
	input wire          sample_valid,
	input wire [11:0]   sample_raw,
	input wire          sample_start,
	input wire [4:0]    sample_channel,
	input wire          irq_request
);
	logic [2:0] hist_q;
	wire        cause_d = (pready && pwrite) || event_in || sample_valid || debug_halt;

	// Recent start causes
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn)
			hist_q <= 3'h0;
		else
			hist_q <= {hist_q[1:0], cause_d};
	end

	default clocking @(posedge pclk); endclocking
	default disable iff (!presetn);

	chk_apb_wait: assert property (psel && !penable |=> !pready ##1 pready)
		else $error("pready not in second access cycle");
	chk_ready_pulse: assert property (pready |=> !pready)
		else $error("pready longer than one cycle");
	chk_err_qual: assert property (pslverr |-> pready)
		else $error("pslverr without pready");
	chk_misalign_refused: assert property (pready && paddr[1:0] != 2'h0 |->
		pslverr && prdata == 32'h0000_0000) else $error("misaligned not refused");
	chk_upper_zero: assert property (pready |-> prdata[31:8] == 24'h00_0000)
		else $error("upper read bits not zero");
	chk_irq_rise: assert property ($rose(irq_request) |->
		$past(sample_valid, 2) || $past(pready && pwrite)) else $error("irq rose without cause");
	chk_irq_fall: assert property ($fell(irq_request) |-> $past(pready))
		else $error("irq fell without access");
	chk_start_pulse: assert property (sample_start |=> !sample_start)
		else $error("sample_start longer than one cycle");
	chk_start_cause: assert property (sample_start |-> |hist_q)
		else $error("sample_start without cause");
	chk_chan_hold: assert property ($changed(sample_channel) |-> $past(sample_valid) ||
		$past(event_in) || $past(pready && pwrite && paddr[6:2] == 5'h08))
		else $error("channel changed mid conversion");

	cover property (sample_start);
	cover property ($rose(irq_request));
	cover property (pslverr);
endmodule // accr_chk

bind accr_top accr_chk #(.AW(AW)) chk_u (.pclk, .presetn, .psel, .penable, .pwrite,
	.paddr, .pwdata, .prdata, .pready, .pslverr, .event_in, .debug_halt, .sample_valid,
	.sample_raw, .sample_start, .sample_channel, .irq_request);

// >>> accr_top_bench.sv
`timescale 1ns/1ns
`include "accr_regs.vh"
module accr_top_bench;
	logic        pclk;
	logic        presetn;
	logic        psel;
	logic        penable;
	logic        pwrite;
	logic [7:0]  paddr;
	logic [31:0] pwdata;
	wire  [31:0] prdata;
	wire         pready;
	wire         pslverr;
	logic        event_in;
	logic        debug_halt;
	logic        sample_valid;
	logic [11:0] sample_raw;
	wire         sample_start;
	wire  [4:0]  sample_channel;
	wire         irq_request;
	logic [31:0] rdat;
	logic        rerr;
	int          bad_count;
	int          tests_run;
	int          cyc;
	int          nstart;
	int          n0;
	logic [4:0]  ci [7] = '{5'h00, 5'h0B, 5'h1C, 5'h1D, 5'h1E, 5'h1F, 5'h0C};
	logic [11:0] cr [7] = '{12'hF00, 12'h7FF, 12'h155, 12'h000, 12'h3FF, 12'h400, 12'h001};
	logic [4:0]  ui [5] = '{`ACCR_IDX_CHAN, `ACCR_IDX_EVT, `ACCR_IDX_IEN, `ACCR_IDX_DBG,
		`ACCR_IDX_TEMP};
	logic [7:0]  ue [5] = '{8'h1F, 8'h01, 8'h03, 8'h01, 8'hFF};
	logic [4:0]  ri [11] = '{`ACCR_IDX_CHAN, `ACCR_IDX_CMD, `ACCR_IDX_EVT, `ACCR_IDX_IEN,
		`ACCR_IDX_FLG, `ACCR_IDX_DBG, `ACCR_IDX_TEMP, `ACCR_IDX_RESL, `ACCR_IDX_RESH,
		`ACCR_IDX_WLOL, `ACCR_IDX_WLOH};
	logic [2:0]  wm [7] = '{3'h0, 3'h1, 3'h2, 3'h3, 3'h4, 3'h1, 3'h4};
	logic [6:0]  wx = 7'h68;

	accr_top dut_u (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .event_in(event_in), .debug_halt(debug_halt),
		.sample_valid(sample_valid), .sample_raw(sample_raw), .sample_start(sample_start),
		.sample_channel(sample_channel), .irq_request(irq_request));

	initial begin
		pclk = 1'b0;
		forever #50 pclk = ~pclk;
	end

	always @(posedge pclk) begin
		cyc++;
		if (sample_start === 1'b1)
			nstart++;
		if (cyc == 20000) begin
			bad_count++;
			close_out();
		end
	end

	// ----------------------------------------
	// Access tasks
	// ----------------------------------------
	task automatic xfer(input logic w, input logic [7:0] a, input logic [7:0] d);
		psel    <= 1'b1;
		pwrite  <= w;
		paddr   <= a;
		pwdata  <= {24'h00_0000, d};
		@(posedge pclk);
		penable <= 1'b1;
		@(posedge pclk);
		while (pready !== 1'b1) @(posedge pclk);
		rdat = prdata;
		rerr = pslverr;
		psel    <= 1'b0;
		penable <= 1'b0;
		@(posedge pclk);
	endtask

	task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
		tests_run++;
		if (g !== e) begin
			bad_count++;
			$display("ERROR %s expected %h seen %h", nm, e, g);
		end
	endtask

	task automatic wr(input logic [4:0] i, input logic [7:0] d);
		xfer(1'b1, {1'b0, i, 2'b00}, d);
	endtask

	task automatic rc(input logic [4:0] i, input logic [7:0] e);
		xfer(1'b0, {1'b0, i, 2'b00}, 8'h00);
		chk($sformatf("reg %h", i), {24'h00_0000, e}, rdat);
	endtask

	task automatic rres(input logic [15:0] e);
		rc(`ACCR_IDX_RESL, e[7:0]);
		rc(`ACCR_IDX_RESH, e[15:8]);
	endtask

	task automatic wstart;
		while (sample_start !== 1'b1) @(posedge pclk);
	endtask

	task automatic pulse(input logic [11:0] r);
		sample_valid <= 1'b1;
		sample_raw   <= r;
		@(posedge pclk);
		sample_valid <= 1'b0;
	endtask

	task automatic conv(input logic [11:0] r, input int n, input logic [4:0] ec);
		wr(`ACCR_IDX_CMD, 8'h01);
		repeat (n) begin
			wstart();
			chk("chan", {27'h000_0000, ec}, {27'h000_0000, sample_channel});
			rc(`ACCR_IDX_CMD, 8'h01);
			pulse(r);
		end
	endtask

	task automatic ev;
		event_in <= 1'b1;
		@(posedge pclk);
		event_in <= 1'b0;
	endtask

	function automatic logic [15:0] clip(input logic [11:0] r);
		return r[11] ? 16'h0000 : (r > 12'h3FF ? 16'h03FF : {4'h0, r});
	endfunction

	task automatic close_out;
		$display("checks %0d mismatches %0d", tests_run, bad_count);
		if (bad_count == 0 && tests_run > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask

	// ----------------------------------------
	// Main sequence
	// ----------------------------------------
	initial begin
		{presetn, psel, penable, pwrite, event_in, debug_halt, sample_valid} = 7'h00;
		paddr = 8'h00;
		pwdata = 32'h0000_0000;
		sample_raw = 12'h000;
		repeat (20) @(posedge pclk);
		presetn <= 1'b1;
		@(posedge pclk);
		foreach (ri[i]) rc(ri[i], 8'h00);
		xfer(1'b0, 8'h04, 8'h00);
		chk("unmapped", 1, rerr);
		xfer(1'b0, 8'h19, 8'h00);
		chk("misaligned", 1, rerr);
		chk("misaligned data", 0, rdat);
		xfer(1'b1, 8'h98, 8'h1F);
		chk("high address", 1, rerr);
		rc(`ACCR_IDX_CHAN, 8'h00);
		foreach (ui[i]) begin
			wr(ui[i], 8'hFF);
			rc(ui[i], ue[i]);
			wr(ui[i], 8'h00);
		end
		foreach (ci[i]) begin
			wr(`ACCR_IDX_CHAN, {3'h0, ci[i]});
			conv(cr[i], 1, i == 6 ? 5'h1F : ci[i]);
			rc(`ACCR_IDX_FLG, 8'h01);
			rres(clip(cr[i]));
			rc(`ACCR_IDX_FLG, 8'h00);
			rc(`ACCR_IDX_CMD, 8'h00);
		end
		wr(`ACCR_IDX_CHAN, 8'h03);
		wr(`ACCR_IDX_CMD, 8'h01);
		wstart();
		wr(`ACCR_IDX_CHAN, 8'h07);
		chk("chan", 32'h0000_0003, {27'h000_0000, sample_channel});
		pulse(12'h010);
		conv(12'h010, 1, 5'h07);
		wr(`ACCR_IDX_WLOL, 8'h00);
		wr(`ACCR_IDX_WLOH, 8'h01);
		wr(`ACCR_IDX_WHIL, 8'h00);
		wr(`ACCR_IDX_WHIH, 8'h02);
		rc(`ACCR_IDX_WLOL, 8'h00);
		rc(`ACCR_IDX_WLOH, 8'h01);
		wr(`ACCR_IDX_IEN, 8'h02);
		foreach (wm[i]) begin
			wr(`ACCR_IDX_MODE, {1'b0, wm[i], 4'h0});
			conv(i < 5 ? 12'h155 : 12'h050, 1, 5'h07);
			rc(`ACCR_IDX_FLG, {6'h00, wx[i], 1'b1});
			chk("irq", {31'h0000_0000, wx[i]}, {31'h0000_0000, irq_request});
			wr(`ACCR_IDX_FLG, 8'h00);
			rc(`ACCR_IDX_FLG, {6'h00, wx[i], 1'b1});
			wr(`ACCR_IDX_FLG, 8'h03);
			rc(`ACCR_IDX_FLG, 8'h00);
		end
		wr(`ACCR_IDX_WLOH, 8'h04);
		wr(`ACCR_IDX_MODE, 8'h1C);
		conv(12'h7FF, 64, 5'h07);
		rc(`ACCR_IDX_FLG, 8'h01);
		rres(16'hFFC0);
		wr(`ACCR_IDX_MODE, 8'h01);
		conv(12'h020, 2, 5'h07);
		wstart();
		rc(`ACCR_IDX_FLG, 8'h01);
		wr(`ACCR_IDX_MODE, 8'h00);
		pulse(12'h020);
		rc(`ACCR_IDX_CMD, 8'h00);
		wr(`ACCR_IDX_MODE, 8'h5E);
		conv(12'h020, 1, 5'h07);
		rc(`ACCR_IDX_FLG, 8'h01);
		rres(16'h0020);
		wr(`ACCR_IDX_EVT, 8'h01);
		debug_halt <= 1'b1;
		n0 = nstart;
		ev();
		repeat (10) @(posedge pclk);
		chk("halt", n0, nstart);
		wr(`ACCR_IDX_DBG, 8'h01);
		ev();
		wstart();
		pulse(12'h030);
		debug_halt <= 1'b0;
		wr(`ACCR_IDX_IEN, 8'h01);
		chk("irq", 1, {31'h0000_0000, irq_request});
		rres(16'h0030);
		chk("irq", 0, {31'h0000_0000, irq_request});
		close_out();
	end
endmodule // accr_top_bench
